// >>> hdl/tws_eeprom.sv
// Two-wire EEPROM slave: framing, addressing, page buffer, programming
`timescale 1ns/1ps
`default_nettype none
module tws_eeprom #(
	parameter int PROG_CYCLES = tws_pkg::PROG_CYCLES_DEF
) (
	input wire logic CLK,
	input wire logic RST,
	input wire logic SCL,
	input wire logic SDA_IN,
	output var logic SDA_OUT,
	output var logic SDA_OE,
	input wire logic [tws_pkg::CS_W-1:0] CHIP_SEL,
	input wire logic WRITE_PROTECT,
	output var logic STANDBY
);
	import tws_pkg::*;

	//*******************************************************************
	// Declarations
	//*******************************************************************
	tws_state_t state_reg;
	logic [1:0] link_s;
	logic [3:0] pin_s;
	logic scl_s, sda_s, wp_s;
	logic [CS_W-1:0] cs_s;
	logic scl_prev_reg, sda_prev_reg;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic busy, active, last_bit, dev_match;
	logic [3:0] cnt_reg;
	logic ack_ok_reg, tx_mode_reg, host_ack_reg;
	logic [7:0] shift_reg, byte_in, tx_reg;
	logic [ADDR_W-1:0] addr_reg;
	logic [15:0] mask_reg;
	logic load_tx, wr_data, rd_done, buf_we;
	logic [PROG_CNT_W-1:0] prog_cnt_reg;
	logic [4:0] walk_reg;
	logic walk_vld_reg;
	logic [COL_W-1:0] walk_col_reg;
	logic prog_done, arr_we;
	logic [7:0] arr_rdata, buf_rdata;

	//*******************************************************************
	// Pin synchronisers
	//*******************************************************************
	tws_sync #(.W(2), .RST_VAL(2'h3)) u_link_sync (
		.clk(CLK),
		.rst(RST),
		.din({SCL, SDA_IN}),
		.dout(link_s)
	);

	// Floating select and protect pins are expected pulled low
	tws_sync #(.W(4), .RST_VAL(4'h0)) u_pin_sync (
		.clk(CLK),
		.rst(RST),
		.din({WRITE_PROTECT, CHIP_SEL}),
		.dout(pin_s)
	);

	assign scl_s = link_s[1];
	assign sda_s = link_s[0];
	assign wp_s = pin_s[3];
	assign cs_s = pin_s[2:0];

	// Previous levels for edge finding
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			scl_prev_reg <= 1'b1;
			sda_prev_reg <= 1'b1;
		end
		else
		begin
			scl_prev_reg <= scl_s;
			sda_prev_reg <= sda_s;
		end
	end

	//*******************************************************************
	// Bus events and decode
	//*******************************************************************
	assign scl_rise = scl_s & ~scl_prev_reg;
	assign scl_fall = ~scl_s & scl_prev_reg;
	assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
	assign stop_det = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;
	assign busy = (state_reg == S_PROG);
	assign active = (state_reg == S_DEV) || (state_reg == S_WADDR) ||
		(state_reg == S_WDATA) || (state_reg == S_RDATA);
	assign byte_in = {shift_reg[6:0], sda_s};
	assign last_bit = active && scl_rise && (cnt_reg == BIT_LAST);
	assign dev_match = (byte_in[7:4] == DEV_CODE) &&
		(byte_in[3:1] == cs_s);
	assign load_tx = active && scl_fall && (cnt_reg == CNT_REL) &&
		(state_reg == S_RDATA) && (!tx_mode_reg || host_ack_reg);
	assign wr_data = last_bit && (state_reg == S_WDATA);
	assign rd_done = last_bit && tx_mode_reg;
	assign buf_we = wr_data && !wp_s;
	assign prog_done = busy &&
		(prog_cnt_reg == PROG_CNT_W'(PROG_CYCLES - 1));

	//*******************************************************************
	// Command sequencer
	//*******************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			state_reg <= S_STANDBY;
			cnt_reg <= 4'h0;
			ack_ok_reg <= 1'b0;
			tx_mode_reg <= 1'b0;
			host_ack_reg <= 1'b0;
		end
		else if (busy)
		begin
			// Deaf until the cycle ends
			if (prog_done)
				state_reg <= S_STANDBY;
		end
		else if (start_det)
		begin
			state_reg <= S_DEV;
			cnt_reg <= 4'h0;
			ack_ok_reg <= 1'b0;
			tx_mode_reg <= 1'b0;
		end
		else if (stop_det)
		begin
			// Stop after loaded write data programs, else standby
			if (state_reg == S_WDATA && mask_reg != 16'h0000)
				state_reg <= S_PROG;
			else
				state_reg <= S_STANDBY;
			ack_ok_reg <= 1'b0;
			tx_mode_reg <= 1'b0;
		end
		else if (active && scl_rise)
		begin
			if (cnt_reg < CNT_ACK)
				cnt_reg <= cnt_reg + 4'h1;
			else if (cnt_reg == CNT_ACK_HI)
				cnt_reg <= CNT_REL;
			if (cnt_reg == CNT_ACK_HI && tx_mode_reg)
				host_ack_reg <= ~sda_s;
			if (cnt_reg == BIT_LAST)
			begin
				if (state_reg == S_DEV)
				begin
					ack_ok_reg <= dev_match;
					if (!dev_match)
						state_reg <= S_STANDBY;
					else if (byte_in[0])
						state_reg <= S_RDATA;
					else
						state_reg <= S_WADDR;
				end
				else if (state_reg == S_WADDR)
				begin
					ack_ok_reg <= 1'b1;
					state_reg <= S_WDATA;
				end
				else
					ack_ok_reg <= (state_reg == S_WDATA);
			end
		end
		else if (active && scl_fall)
		begin
			if (cnt_reg == CNT_ACK)
				cnt_reg <= CNT_ACK_HI;
			else if (cnt_reg == CNT_REL)
			begin
				cnt_reg <= 4'h0;
				if (load_tx)
					tx_mode_reg <= 1'b1;
				else if (state_reg == S_RDATA)
				begin
					state_reg <= S_STANDBY;
					tx_mode_reg <= 1'b0;
				end
			end
		end
	end

	// Receive shifter, sampled on SCL rise
	always_ff @(posedge CLK)
	begin
		if (RST)
			shift_reg <= 8'h00;
		else if (active && scl_rise && cnt_reg < CNT_ACK)
			shift_reg <= byte_in;
	end

	//*******************************************************************
	// Address counter
	//*******************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
			addr_reg <= ADDR_RST;
		else if (last_bit && state_reg == S_WADDR)
			addr_reg <= byte_in;
		else if (wr_data)
			addr_reg <= {addr_reg[7:4], addr_reg[3:0] + 4'h1};
		else if (rd_done)
			addr_reg <= addr_reg + 8'h01;
	end

	//*******************************************************************
	// SDA driver: acknowledge and read data, open drain
	//*******************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
		begin
			SDA_OE <= 1'b0;
			tx_reg <= 8'h00;
		end
		else if (busy || start_det || stop_det || !active)
			SDA_OE <= 1'b0;
		else if (scl_fall)
		begin
			if (load_tx)
			begin
				tx_reg <= {arr_rdata[6:0], 1'b0};
				SDA_OE <= ~arr_rdata[7];
			end
			else if (tx_mode_reg && cnt_reg != 4'h0 && cnt_reg < CNT_ACK)
			begin
				SDA_OE <= ~tx_reg[7];
				tx_reg <= {tx_reg[6:0], 1'b0};
			end
			else if (cnt_reg == CNT_ACK)
				SDA_OE <= ack_ok_reg && !tx_mode_reg;
			else if (cnt_reg == CNT_REL)
				SDA_OE <= 1'b0;
		end
	end

	assign SDA_OUT = 1'b0;
	assign STANDBY = (state_reg == S_STANDBY);

	//*******************************************************************
	// Page buffer and loaded-column mask
	//*******************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST)
			mask_reg <= 16'h0000;
		else if ((start_det && !busy) || prog_done)
			mask_reg <= 16'h0000;
		else if (buf_we)
			mask_reg[addr_reg[3:0]] <= 1'b1;
	end

	tws_mem #(.AW(COL_W)) u_page_buf (
		.clk(CLK),
		.we(buf_we),
		.waddr(addr_reg[3:0]),
		.wdata(byte_in),
		.raddr(walk_reg[3:0]),
		.rdata(buf_rdata)
	);

	//*******************************************************************
	// Self-timed programming: copy marked columns, then wait
	//*******************************************************************
	always_ff @(posedge CLK)
	begin
		if (RST || !busy)
		begin
			prog_cnt_reg <= PROG_CNT_W'(0);
			walk_reg <= 5'h00;
			walk_vld_reg <= 1'b0;
			walk_col_reg <= 4'h0;
		end
		else
		begin
			prog_cnt_reg <= prog_cnt_reg + PROG_CNT_W'(1);
			walk_vld_reg <= (walk_reg != WALK_END);
			walk_col_reg <= walk_reg[3:0];
			if (walk_reg != WALK_END)
				walk_reg <= walk_reg + 5'h01;
		end
	end

	assign arr_we = walk_vld_reg && mask_reg[walk_col_reg];

	tws_mem #(.AW(ADDR_W)) u_array (
		.clk(CLK),
		.we(arr_we),
		.waddr({addr_reg[7:4], walk_col_reg}),
		.wdata(buf_rdata),
		.raddr(addr_reg),
		.rdata(arr_rdata)
	);

	//*******************************************************************
	// Assertions
	//*******************************************************************
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (RST);

	sequence s_last_bit;
		scl_rise && cnt_reg == 4'h7 && active;
	endsequence

	sequence s_prog_hold;
		busy [*8];
	endsequence

	property p_start;
		start_det && !busy |=> state_reg == S_DEV && cnt_reg == 4'h0;
	endproperty
	a_start: assert property (p_start)
		else $error("start not decoded");

	property p_stop_prog;
		stop_det && state_reg == S_WDATA && mask_reg != 16'h0000
			|=> busy;
	endproperty
	a_stop_prog: assert property (p_stop_prog)
		else $error("stop after write did not program");

	property p_prog_quiet;
		$rose(busy) |-> s_prog_hold ##0 !SDA_OE;
	endproperty
	a_prog_quiet: assert property (p_prog_quiet)
		else $error("programming cycle cut short or driving");

	property p_release;
		SDA_OE |-> (tx_mode_reg && cnt_reg <= 4'h8) ||
			(!tx_mode_reg && cnt_reg >= 4'h9);
	endproperty
	a_release: assert property (p_release)
		else $error("SDA driven outside ack or data");

	property p_mismatch;
		s_last_bit ##0 (state_reg == S_DEV && !dev_match)
			|=> STANDBY ##[1:40] !SDA_OE;
	endproperty
	a_mismatch: assert property (p_mismatch)
		else $error("mismatched address not ignored");

	property p_col_wrap;
		s_last_bit ##0 state_reg == S_WDATA |=>
			addr_reg[7:4] == $past(addr_reg[7:4]) &&
			addr_reg[3:0] == 4'($past(addr_reg[3:0]) + 4'h1);
	endproperty
	a_col_wrap: assert property (p_col_wrap)
		else $error("column increment wrong");

	property p_rd_inc;
		s_last_bit ##0 tx_mode_reg |=>
			addr_reg == 8'($past(addr_reg) + 8'h01);
	endproperty
	a_rd_inc: assert property (p_rd_inc)
		else $error("read counter not incremented");

	property p_wp;
		wr_data && wp_s |=> mask_reg == $past(mask_reg);
	endproperty
	a_wp: assert property (p_wp)
		else $error("write loaded while protected");

	property p_ack;
		scl_fall && cnt_reg == 4'h8 && active && ack_ok_reg &&
			!tx_mode_reg && !start_det |=> SDA_OE && cnt_reg == 4'h9;
	endproperty
	a_ack: assert property (p_ack)
		else $error("acknowledge missing");

endmodule : tws_eeprom
`default_nettype wire

// >>> hdl/tws_pkg.sv
// Constants, types and timing for the two-wire EEPROM slave
//***********************************************************************
// What this block does
// - Sample on SCL rise, drive on fall
// - Unconnected select pins read as low
// - Protect high blocks programming, reads unaffected
// - Array is 16 pages of 16 bytes
// - SDA fall with SCL high starts command
// - SDA rise with SCL high ends command
// - Stop after write starts programming cycle
// - Acknowledge each received byte on ninth clock
// - Standby after power-up, read stop, programming
// - Address byte is 1010 plus select bits
// - Match acknowledges; mismatch goes silent to standby
// - Address LSB one reads, zero writes
// - Byte write acknowledged at clocks 9,18,27
// - Inputs ignored during programming cycle
// - Page write acknowledges each further data byte
// - Page write increments only column bits, wrapping at 16
// - Page write may start at any column
// - No address acknowledge while still programming
// - Counter holds last address plus one
// - Read sends counter byte then increments
// - Host ack gets next byte, counter wraps
// - New start abandons pending page write
//***********************************************************************
package tws_pkg;

	localparam int ADDR_W = 8;
	localparam int COL_W = 4;
	localparam int DATA_W = 8;
	localparam int CS_W = 3;
	localparam logic [3:0] DEV_CODE = 4'hA;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] CNT_ACK = 4'h8;
	localparam logic [3:0] CNT_ACK_HI = 4'h9;
	localparam logic [3:0] CNT_REL = 4'hA;
	localparam logic [4:0] WALK_END = 5'h10;
	localparam logic [7:0] ADDR_RST = 8'h00;

	// Programming time and its cycle count at the core clock
	localparam int PROG_TIME_NS = 5000000;
	localparam int CLK_PERIOD_NS = 25;
	localparam int PROG_CYCLES_DEF = PROG_TIME_NS / CLK_PERIOD_NS;
	localparam int PROG_CNT_W = 18;

	typedef enum logic [2:0] {
		S_STANDBY,
		S_DEV,
		S_WADDR,
		S_WDATA,
		S_RDATA,
		S_PROG
	} tws_state_t;

endpackage : tws_pkg

// >>> hdl/tws_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module tws_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] din,
	output var logic [W-1:0] dout
);
	logic [W-1:0] ff1_reg;
	logic [W-1:0] ff2_reg;
	logic [W-1:0] ff3_reg;

	// Chain; only ff2 reads ff1
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			ff1_reg <= RST_VAL;
			ff2_reg <= RST_VAL;
			ff3_reg <= RST_VAL;
		end
		else
		begin
			ff1_reg <= din;
			ff2_reg <= ff1_reg;
			ff3_reg <= ff2_reg;
		end
	end

	// Output follows once stages two and three agree, per bit
	always_ff @(posedge clk)
	begin
		if (rst)
			dout <= RST_VAL;
		else
			dout <= (ff2_reg & ~(ff2_reg ^ ff3_reg)) |
				(dout & (ff2_reg ^ ff3_reg));
	end
endmodule : tws_sync
`default_nettype wire

// >>> hdl/tws_mem.sv
// Simple dual-port byte memory with registered read data
`timescale 1ns/1ps
`default_nettype none
module tws_mem #(
	parameter int AW = 8
) (
	input wire logic clk,
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [7:0] wdata,
	input wire logic [AW-1:0] raddr,
	output var logic [7:0] rdata
);
	logic [7:0] mem [0:(1<<AW)-1];

	// Write port
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
	end

	// Registered read port
	always_ff @(posedge clk)
	begin
		rdata <= mem[raddr];
	end
endmodule : tws_mem
`default_nettype wire

// >>> sim/tws_host.sv
// Host bus master model driving SCL and pulling SDA
`timescale 1ns/1ps
`default_nettype none
module tws_host (
	input wire logic clk,
	input wire logic sda,
	output var logic scl,
	output var logic sda_low
);
	// Idle bus: clock high, data released
	initial
	begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge clk);
	endtask : hold
	// One bit: data set mid low phase, sampled mid high
	task automatic put(input logic b, output logic s);
		hold(8);
		sda_low <= ~b;
		hold(8);
		scl <= 1'b1;
		hold(3);
		@(negedge clk);
		s = sda;
		hold(4);
		scl <= 1'b0;
	endtask : put
	// Start, also usable as a repeated start
	task automatic start();
		sda_low <= 1'b0;
		hold(8);
		scl <= 1'b1;
		hold(8);
		sda_low <= 1'b1;
		hold(8);
		scl <= 1'b0;
	endtask : start
	task automatic stop();
		hold(8);
		sda_low <= 1'b1;
		hold(8);
		scl <= 1'b1;
		hold(8);
		sda_low <= 1'b0;
		hold(8);
	endtask : stop
	// Byte out MSB first, returns the ninth bit
	task automatic send(input logic [7:0] v, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			put(v[i], s);
		put(1'b1, ack);
	endtask : send
	// Byte in, then host ack or no-ack
	task automatic recv(input logic nack, output logic [7:0] v);
		logic s;
		for (int i = 7; i >= 0; i--)
			put(1'b1, v[i]);
		put(nack, s);
	endtask : recv
endmodule : tws_host
`default_nettype wire

// >>> sim/tws_eeprom_bench.sv
// Self-checking bench for the two-wire EEPROM slave
`timescale 1ns/1ps
`default_nettype none
module tws_eeprom_bench;
	import tws_pkg::*;
	localparam int PROG = 400;
	logic clk, rst, scl, sda_low, sda, sda_out, sda_oe, standby, wp;
	logic [2:0] cs;
	logic [7:0] model [256];
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	// Address rows: select pins, address byte, ack bit expected
	typedef struct {logic [2:0] c; logic [7:0] d; logic a;} tws_row_t;
	tws_row_t rows [6] = '{'{3'h0, 8'hA0, 1'b0}, '{3'h5, 8'hAA, 1'b0},
		'{3'h5, 8'hA0, 1'b1}, '{3'h0, 8'hB0, 1'b1},
		'{3'h3, 8'hA7, 1'b0}, '{3'h3, 8'hA5, 1'b1}};
	//****
	// Clock, wire and instances
	//****
	initial
	begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	// Open-drain wire with pull-up
	assign sda = (sda_oe ? sda_out : 1'b1) & ~sda_low;
	tws_eeprom #(.PROG_CYCLES(PROG)) DUT (.CLK(clk), .RST(rst), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .CHIP_SEL(cs),
		.WRITE_PROTECT(wp), .STANDBY(standby));
	tws_host host (.clk(clk), .sda(sda), .scl(scl), .sda_low(sda_low));
	//****
	// Checking tasks
	//****
	task automatic compare(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : compare
	task automatic finish_test();
		if (num_errors == 0 && checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : finish_test
	// Hang guard
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			num_errors++;
			finish_test();
		end
	end
	// Start, write address byte, word address
	task automatic waddr(input logic [7:0] a);
		logic k;
		host.start();
		host.send({DEV_CODE, cs, 1'b0}, k);
		compare(k, 1'b0);
		host.send(a, k);
		compare(k, 1'b0);
	endtask : waddr
	// Page or byte write, programming and polling
	task automatic pwrite(input logic [7:0] a, input logic [7:0] d0,
		input int n);
		logic k;
		waddr(a);
		for (int i = 0; i < n; i++)
		begin
			host.send(d0 + 8'(i), k);
			compare(k, 1'b0);
			if (!wp)
				model[{a[7:4], a[3:0] + 4'(i)}] = d0 + 8'(i);
		end
		host.stop();
		if (!wp)
		begin
			compare(standby, 1'b0);
			host.start();
			host.send({DEV_CODE, cs, 1'b0}, k);
			compare(k, 1'b1);
			host.stop();
		end
		for (int i = 0; i < 4 * PROG && !standby; i++)
			@(posedge clk);
		host.hold(PROG);
		compare(standby, 1'b1);
	endtask : pwrite
	// Current address read of n bytes against the model
	task automatic cread(input logic [7:0] a, input int n);
		logic k;
		logic [7:0] v;
		host.start();
		host.send({DEV_CODE, cs, 1'b1}, k);
		compare(k, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			host.recv(i == n - 1, v);
			compare(v, model[a + 8'(i)]);
		end
		host.stop();
	endtask : cread
	//****
	// Main sequence
	//****
	initial
	begin
		logic k;
		logic [7:0] v;
		rst = 1'b1;
		wp = 1'b0;
		cs = 3'h0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		host.hold(6);
		compare(standby, 1'b1);
		compare(sda_oe, 1'b0);
		// Address matching rows
		foreach (rows[i])
		begin
			cs <= rows[i].c;
			host.hold(8);
			host.start();
			host.send(rows[i].d, k);
			compare(k, rows[i].a);
			if (rows[i].d[0] && !k)
				host.recv(1'b1, v);
			host.stop();
			compare(sda_oe, 1'b0);
		end
		cs <= 3'h0;
		host.hold(8);
		pwrite(8'hFF, 8'h5A, 1);
		pwrite(8'h0E, 8'h10, 18);
		wp <= 1'b1;
		host.hold(2);
		pwrite(8'hFF, 8'h00, 1);
		wp <= 1'b0;
		waddr(8'hFF);
		cread(8'hFF, 3);
		waddr(8'h05);
		cread(8'h05, 2);
		cread(8'h07, 1);
		// Restart after a data byte drops the pending write
		waddr(8'h01);
		host.send(8'h77, k);
		host.start();
		host.stop();
		host.hold(16);
		compare(standby, 1'b1);
		waddr(8'h01);
		cread(8'h01, 1);
		finish_test();
	end
endmodule : tws_eeprom_bench
`default_nettype wire
